// [bridge_pwm_pkg.sv]
// Constants and types for the bridge PWM output stage
// Contract
// - Polarity field inverts or passes pair A/C and pair B/D separately.
// - Period flag rises when the second PWM period begins.
// - Three source bits: comparator one, comparator two, low shutdown pin; ORed.
// - Any enabled event sets shutdown status until software or restart clears it.
// - Software writing one to shutdown status forces shutdown.
// - Shutdown puts pins into shutdown state at once, without a clock edge.
// - Pins A and C in shutdown: 00 low, 01 high, 1x released.
// - Pins B and D in shutdown: 00 low, 01 high, 1x released.
// - Triggers are levels; shutdown holds while an enabled level remains.
// - Writes to shutdown status are ignored while a condition is present.
// - Output resumes only at the next period start after shutdown ends.
// - With restart enabled hardware clears status once the condition is gone.
// - Synchronised comparator two shutdown waits for the secondary timer edge.
// - Half-bridge dead band delays only inactive-to-active edges.
// - Seven-bit delay count gives instruction cycles before the active edge.
// - Steering works only with mode-select 11 and bridge mode 00.
// - Steered pins all carry the same modulated waveform, one to four.
// - Polarity field sets polarity of all steered pins.
// - Shutdown in steering alters only steered pins.
// - Half-bridge puts waveform on pin A, complement on pin B.
// - Steering enable one routes waveform; zero gives ordinary port output.
// - Steer sync one defers steering changes to next period start.
package bridge_pwm_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_CAPTURE_PWM_CONTROL     = 3'h0;
    localparam logic [2:0] ADDR_AUTO_SHUTDOWN_CONTROL   = 3'h1;
    localparam logic [2:0] ADDR_RESTART_AND_DEADBAND    = 3'h2;
    localparam logic [2:0] ADDR_STEER_CONTROL           = 3'h3;
    localparam logic [2:0] ADDR_STATUS                  = 3'h4;
    localparam logic [2:0] ADDR_PORT_LATCH              = 3'h5;

    localparam logic [7:0] RESET_CAPTURE_PWM_CONTROL    = 8'h00;
    localparam logic [7:0] RESET_AUTO_SHUTDOWN_CONTROL  = 8'h00;
    localparam logic [7:0] RESET_RESTART_AND_DEADBAND   = 8'h00;
    localparam logic [4:0] RESET_STEER_CONTROL          = 5'h01;
    localparam logic [3:0] RESET_PORT_LATCH             = 4'h0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BRIDGE_MODE_LSB    = 6;
    localparam int MODE_SELECT_LSB    = 2;
    localparam int SHUTDOWN_STATUS    = 7;
    localparam int SOURCE_LSB         = 4;
    localparam int PAIR_AC_LSB        = 2;
    localparam int PAIR_BD_LSB        = 0;
    localparam int RESTART_ENABLE     = 7;
    localparam int STEER_SYNC         = 4;
    localparam int STATUS_FLAG        = 0;
    localparam int STATUS_SHUT        = 1;
    localparam int STATUS_RUN         = 2;

    localparam logic [1:0] MODE_SELECT_PWM   = 2'b11;
    localparam logic [1:0] BRIDGE_SINGLE     = 2'b00;
    localparam logic [1:0] BRIDGE_FULL_FWD   = 2'b01;
    localparam logic [1:0] BRIDGE_HALF       = 2'b10;
    localparam logic [1:0] BRIDGE_FULL_REV   = 2'b11;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_RUN  = 4'b0100,
        ST_SHUT = 4'b1000
    } run_state_t;

    typedef struct packed {
        logic [7:0] addr_pad;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        run_state_t state;
        logic [7:0] capture_pwm_control;
        logic [7:0] auto_shutdown_control;
        logic [7:0] restart_and_deadband;
        logic [4:0] steer_written;
        logic [3:0] steer_enables;
        logic [3:0] port_latch;
        logic       period_timer_flag;
        logic       cmp2_held;
        logic [6:0] delay_a;
        logic [6:0] delay_b;
        logic [3:0] pin_level;
        logic [3:0] pwm_pins;
        logic [7:0] rdata;
    } state_t;

endpackage

// [bridge_pwm_output_stage.sv]
// Polarity, dead band, auto-shutdown and steering output stage
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module bridge_pwm_output_stage
    import bridge_pwm_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata,
    input  wire logic       i_pwm,
    input  wire logic       i_period_start,
    input  wire logic       i_cmp1,
    input  wire logic       i_cmp2,
    input  wire logic       i_comparator_two_sync,
    input  wire logic       i_sec_timer_edge,
    input  wire logic       i_shutdown_pin_n,
    output logic            o_period_timer_flag,
    output logic [3:0]      o_out,
    output logic [3:0]      o_out_oe_n
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic pol(input logic v, input logic inv);
        pol = v ^ inv;
    endfunction

    function automatic logic [1:0] sd_pin(input logic [1:0] f);
        // Returns {release, level}
        sd_pin = {f[1], f[0] & ~f[1]};
    endfunction

    state_t q;
    state_t d;

    logic       cmp2_eff;
    logic       cond;
    logic       shut_now;
    logic [1:0] mode_sel;
    logic [1:0] bridge;
    logic       enhanced;
    logic [1:0] sd_ac;
    logic [1:0] sd_bd;

    // ------------------------------------------------------------
    // Shutdown condition
    // ------------------------------------------------------------
    always_comb begin
        // Comparator two is held until the secondary timer edge
        cmp2_eff = i_comparator_two_sync ? q.cmp2_held : i_cmp2;
        cond = (q.auto_shutdown_control[SOURCE_LSB]     & i_cmp1)
             | (q.auto_shutdown_control[SOURCE_LSB + 1] & cmp2_eff)
             | (q.auto_shutdown_control[SOURCE_LSB + 2]
                & ~i_shutdown_pin_n);
        // Status bit or live level both hold shutdown
        shut_now = q.auto_shutdown_control[SHUTDOWN_STATUS]
                 | cond;
        mode_sel = q.capture_pwm_control[MODE_SELECT_LSB +: 2];
        bridge   = q.capture_pwm_control[BRIDGE_MODE_LSB +: 2];
        enhanced = (mode_sel == MODE_SELECT_PWM);
        sd_ac = sd_pin(q.auto_shutdown_control[PAIR_AC_LSB +: 2]);
        sd_bd = sd_pin(q.auto_shutdown_control[PAIR_BD_LSB +: 2]);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] want;
        logic [3:0] lvl;
        logic [3:0] pins;
        logic       inv_ac;
        logic       inv_bd;
        logic       a_on;
        logic       b_on;
        want   = 4'h0;
        lvl    = 4'h0;
        pins   = 4'h0;
        inv_ac = q.capture_pwm_control[1];
        inv_bd = q.capture_pwm_control[0];
        a_on   = 1'b0;
        b_on   = 1'b0;
        d      = q;

        // Register writes
        if (i_wr) begin
            unique case (i_addr)
                ADDR_CAPTURE_PWM_CONTROL: begin
                    d.capture_pwm_control = i_wdata;
                end
                ADDR_AUTO_SHUTDOWN_CONTROL: begin
                    d.auto_shutdown_control[6:0] = i_wdata[6:0];
                    // Ignored while a trigger is live
                    if (!cond) begin
                        d.auto_shutdown_control[SHUTDOWN_STATUS] =
                            i_wdata[SHUTDOWN_STATUS];
                    end
                end
                ADDR_RESTART_AND_DEADBAND: begin
                    d.restart_and_deadband = i_wdata;
                end
                ADDR_STEER_CONTROL: begin
                    d.steer_written = i_wdata[4:0];
                    if (!i_wdata[STEER_SYNC]) begin
                        d.steer_enables = i_wdata[3:0];
                    end
                end
                ADDR_STATUS: begin
                    if (!i_wdata[STATUS_FLAG]) begin
                        d.period_timer_flag = 1'b0;
                    end
                end
                ADDR_PORT_LATCH: begin
                    d.port_latch = i_wdata[3:0];
                end
                default: begin
                end
            endcase
        end

        // Deferred steering update
        if (i_period_start && q.steer_written[STEER_SYNC]) begin
            d.steer_enables = q.steer_written[3:0];
        end

        // Hardware set beats software clear
        if (cond) begin
            d.auto_shutdown_control[SHUTDOWN_STATUS] = 1'b1;
        end else if (q.restart_and_deadband[RESTART_ENABLE]
                     && q.auto_shutdown_control[SHUTDOWN_STATUS]) begin
            d.auto_shutdown_control[SHUTDOWN_STATUS] = 1'b0;
        end

        if (i_sec_timer_edge) begin
            d.cmp2_held = i_cmp2;
        end

        // Period flag: first start opens the period, second sets flag
        if (i_period_start && q.state == ST_RUN) begin
            d.period_timer_flag = 1'b1;
        end

        // Run control
        unique case (q.state)
            ST_IDLE: begin
                if (enhanced) begin
                    d.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!enhanced) begin
                    d.state = ST_IDLE;
                end else if (shut_now) begin
                    d.state = ST_SHUT;
                end else if (i_period_start) begin
                    d.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!enhanced) begin
                    d.state = ST_IDLE;
                end else if (shut_now) begin
                    d.state = ST_SHUT;
                end
            end
            ST_SHUT: begin
                if (!enhanced) begin
                    d.state = ST_IDLE;
                end else if (!shut_now && i_period_start) begin
                    // A start in the first clear cycle still counts
                    d.state = ST_RUN;
                end else if (!shut_now) begin
                    d.state = ST_WAIT;
                end
            end
        endcase

        // Dead band counters, one count per instruction cycle
        if (!i_pwm || q.state != ST_RUN) begin
            d.delay_a = 7'h00;
        end else if (q.delay_a != q.restart_and_deadband[6:0]) begin
            d.delay_a = q.delay_a + 7'h01;
        end
        if (i_pwm || q.state != ST_RUN) begin
            d.delay_b = 7'h00;
        end else if (q.delay_b != q.restart_and_deadband[6:0]) begin
            d.delay_b = q.delay_b + 7'h01;
        end
        // Delay only the turn-on edge; turn-off passes straight
        a_on = i_pwm && (q.delay_a == q.restart_and_deadband[6:0])
               && (q.state == ST_RUN);
        b_on = !i_pwm && (q.delay_b == q.restart_and_deadband[6:0])
               && (q.state == ST_RUN);

        // Active levels before polarity; inactive while waiting
        if (enhanced) begin
            unique case (bridge)
                BRIDGE_SINGLE: begin
                    pins = q.steer_enables;
                    want = {4{i_pwm && q.state == ST_RUN}};
                end
                BRIDGE_HALF: begin
                    pins = 4'b0011;
                    want = {2'b00, b_on, a_on};
                end
                BRIDGE_FULL_FWD: begin
                    pins = 4'b1111;
                    want = {i_pwm, 2'b00, 1'b1}
                         & {4{q.state == ST_RUN}};
                end
                BRIDGE_FULL_REV: begin
                    pins = 4'b1111;
                    want = {1'b0, 1'b1, i_pwm, 1'b0}
                         & {4{q.state == ST_RUN}};
                end
            endcase
        end

        // Same polarity pairing serves steering
        lvl[0] = pol(want[0], inv_ac);
        lvl[2] = pol(want[2], inv_ac);
        lvl[1] = pol(want[1], inv_bd);
        lvl[3] = pol(want[3], inv_bd);
        d.pin_level = (pins & lvl) | (~pins & q.port_latch);
        d.pwm_pins  = pins;

        // Register reads
        d.rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_CAPTURE_PWM_CONTROL: begin
                    d.rdata = q.capture_pwm_control;
                end
                ADDR_AUTO_SHUTDOWN_CONTROL: begin
                    d.rdata = q.auto_shutdown_control;
                end
                ADDR_RESTART_AND_DEADBAND: begin
                    d.rdata = q.restart_and_deadband;
                end
                ADDR_STEER_CONTROL: begin
                    d.rdata = {3'h0, q.steer_written};
                end
                ADDR_STATUS: begin
                    d.rdata = {5'h00, q.state == ST_RUN, shut_now,
                               q.period_timer_flag};
                end
                ADDR_PORT_LATCH: begin
                    d.rdata = {4'h0, q.port_latch};
                end
                default: begin
                    d.rdata = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q.state                 <= ST_IDLE;
            q.capture_pwm_control   <= RESET_CAPTURE_PWM_CONTROL;
            q.auto_shutdown_control <= RESET_AUTO_SHUTDOWN_CONTROL;
            q.restart_and_deadband  <= RESET_RESTART_AND_DEADBAND;
            q.steer_written         <= RESET_STEER_CONTROL;
            q.steer_enables         <= RESET_STEER_CONTROL[3:0];
            q.port_latch            <= RESET_PORT_LATCH;
            q.period_timer_flag     <= 1'b0;
            q.cmp2_held             <= 1'b0;
            q.delay_a               <= 7'h00;
            q.delay_b               <= 7'h00;
            q.pin_level             <= 4'h0;
            q.pwm_pins              <= 4'h0;
            q.rdata                 <= 8'h00;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Shutdown bypasses the output flops so the pins react
    // without waiting for an edge; only PWM-owned pins move.
    always_comb begin
        o_rdata             = q.rdata;
        o_period_timer_flag = q.period_timer_flag;
        o_out               = q.pin_level;
        o_out_oe_n          = 4'h0;
        if (shut_now && enhanced) begin
            if (q.pwm_pins[0]) begin
                o_out[0] = sd_ac[0];
                o_out_oe_n[0] = sd_ac[1];
            end
            if (q.pwm_pins[2]) begin
                o_out[2] = sd_ac[0];
                o_out_oe_n[2] = sd_ac[1];
            end
            if (q.pwm_pins[1]) begin
                o_out[1] = sd_bd[0];
                o_out_oe_n[1] = sd_bd[1];
            end
            if (q.pwm_pins[3]) begin
                o_out[3] = sd_bd[0];
                o_out_oe_n[3] = sd_bd[1];
            end
        end
    end

endmodule // bridge_pwm_output_stage

// [bridge_pwm_asserts.sv]
// Port-level assertions for the bridge PWM output stage
`timescale 1ns/1ps

module bridge_pwm_checker
    import bridge_pwm_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_reset_n,
    input wire logic [2:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       i_pwm,
    input wire logic       i_period_start,
    input wire logic       i_cmp1,
    input wire logic       i_cmp2,
    input wire logic       i_comparator_two_sync,
    input wire logic       i_sec_timer_edge,
    input wire logic       i_shutdown_pin_n,
    input wire logic       o_period_timer_flag,
    input wire logic [3:0] o_out,
    input wire logic [3:0] o_out_oe_n
);
    // ----------------------------------------
    // Shadow of the written configuration
    // ----------------------------------------
    logic [7:0] ctrl_q;
    logic [6:0] asd_q;
    logic [6:0] db_q;
    logic [4:0] steer_q;
    logic [3:0] latch_q;
    logic [1:0] cfg_wr_q;
    logic [7:0] low_cnt_q;
    logic       cfg_wr;
    logic       pwm_on;
    logic       single;
    logic       half;
    logic       steady;
    logic       trig;
    logic [3:0] own;

    assign cfg_wr = i_wr && (i_addr == ADDR_CAPTURE_PWM_CONTROL
        || i_addr == ADDR_STEER_CONTROL || i_addr == ADDR_PORT_LATCH);
    assign pwm_on = ctrl_q[3:2] == MODE_SELECT_PWM;
    assign single = pwm_on && ctrl_q[7:6] == BRIDGE_SINGLE;
    assign half = pwm_on && ctrl_q[7:6] == BRIDGE_HALF;
    // Registered pins lag a config write, and synced steering is deferred
    assign steady = cfg_wr_q == 2'b00 && !steer_q[STEER_SYNC];
    assign trig = (!i_shutdown_pin_n && asd_q[6]) || (i_cmp1 && asd_q[4]);
    assign own = !pwm_on ? 4'h0 : single ? steer_q[3:0]
        : half ? 4'h3 : 4'hF;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q    <= RESET_CAPTURE_PWM_CONTROL;
            asd_q     <= RESET_AUTO_SHUTDOWN_CONTROL[6:0];
            db_q      <= RESET_RESTART_AND_DEADBAND[6:0];
            steer_q   <= RESET_STEER_CONTROL;
            latch_q   <= RESET_PORT_LATCH;
            cfg_wr_q  <= 2'b00;
            low_cnt_q <= 8'h00;
        end else begin
            cfg_wr_q <= {cfg_wr_q[0], cfg_wr};
            if (o_out[0] || o_out[1]) low_cnt_q <= 8'h00;
            else if (low_cnt_q != 8'hFF) low_cnt_q <= low_cnt_q + 8'h01;
            if (i_wr) begin
                case (i_addr)
                    ADDR_CAPTURE_PWM_CONTROL:   ctrl_q  <= i_wdata;
                    ADDR_AUTO_SHUTDOWN_CONTROL: asd_q   <= i_wdata[6:0];
                    ADDR_RESTART_AND_DEADBAND:  db_q    <= i_wdata[6:0];
                    ADDR_STEER_CONTROL:         steer_q <= i_wdata[4:0];
                    ADDR_PORT_LATCH:            latch_q <= i_wdata[3:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    a_shut_ac_level: assert property (
        steady && trig && own[0] && !asd_q[3]
        |-> o_out[0] == asd_q[2] && !o_out_oe_n[0])
        else $error("pin A missed its shutdown level");
    a_shut_bd_float: assert property (
        steady && trig && own[1] && asd_q[1] |-> o_out_oe_n[1])
        else $error("pin B not released in shutdown");
    a_status_while_trig: assert property (
        $past(i_rd && i_addr == ADDR_AUTO_SHUTDOWN_CONTROL)
        && $past(trig) && $past(trig, 2) |-> o_rdata[SHUTDOWN_STATUS])
        else $error("shutdown status low under a live trigger");
    a_flag_on_start: assert property (
        $rose(o_period_timer_flag) |-> $past(i_period_start))
        else $error("period flag rose without a period start");
    a_flag_clear: assert property (
        $fell(o_period_timer_flag) |-> $past(i_wr
        && i_addr == ADDR_STATUS && !i_wdata[STATUS_FLAG]))
        else $error("period flag fell without a clearing write");
    a_port_pin_d: assert property (
        steady && !own[3] |-> o_out[3] == latch_q[3] && !o_out_oe_n[3])
        else $error("unowned pin D not showing the port latch");
    a_pair_ac_match: assert property (
        steady && single && steer_q[0] && steer_q[2]
        |-> o_out[0] == o_out[2] && o_out_oe_n[0] == o_out_oe_n[2])
        else $error("steered pins A and C differ");
    a_no_shoot: assert property (
        steady && half && ctrl_q[1:0] == 2'b00 && asd_q[3:0] == 4'h0
        |-> !(o_out[0] && o_out[1]))
        else $error("half-bridge pins A and B both active");
    a_deadband_gap: assert property (
        $rose(o_out[0]) && steady && half && ctrl_q[1:0] == 2'b00
        && !o_out_oe_n[0] |-> low_cnt_q >= {1'b0, db_q})
        else $error("pin A turned on before the dead band ran out");
endmodule // bridge_pwm_checker

// [switch_driver_model.sv]
// Power switch driver inputs seen through pin pull-downs
`timescale 1ns/1ps

module switch_driver_model (
    input  wire logic [3:0] i_out,
    input  wire logic [3:0] i_out_oe_n,
    output logic [3:0]      o_pin
);
    // Released pins sink to the pull-down so switches stay off
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            o_pin[i] = i_out_oe_n[i] ? 1'b0 : i_out[i];
        end
    end
endmodule // switch_driver_model

// [tb.sv]
// Self-checking bench for the bridge PWM output stage
`timescale 1ns/1ps

module tb;
    import bridge_pwm_pkg::*;

    logic       i_clk = 1'b0;
    logic       i_reset_n = 1'b0;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic       i_wr = 1'b0;
    logic       i_rd = 1'b0;
    logic       i_pwm = 1'b0;
    logic       i_period_start = 1'b0;
    logic       i_cmp1 = 1'b0;
    logic       i_cmp2 = 1'b0;
    logic       i_comparator_two_sync = 1'b0;
    logic       i_sec_timer_edge = 1'b0;
    logic       i_shutdown_pin_n = 1'b1;
    logic [7:0] o_rdata;
    logic       o_period_timer_flag;
    logic [3:0] o_out;
    logic [3:0] o_out_oe_n;
    logic [3:0] pin;
    logic [7:0] db = 8'h03;
    logic [7:0] rst_tab [8];
    int         fail_count = 0;
    int         n_compared = 0;

    always #2 i_clk = ~i_clk;

    bridge_pwm_output_stage dut (.i_clk, .i_reset_n, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata, .i_pwm, .i_period_start, .i_cmp1, .i_cmp2,
        .i_comparator_two_sync, .i_sec_timer_edge, .i_shutdown_pin_n,
        .o_period_timer_flag, .o_out, .o_out_oe_n);
    switch_driver_model drv (.i_out(o_out), .i_out_oe_n(o_out_oe_n),
        .o_pin(pin));

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk) i_wr <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk) i_rd <= 1'b0;
        #1 chk("read", e, o_rdata);
    endtask
    // Pins as {released, level at the switch}
    task automatic pchk(input logic [7:0] e);
        chk("pins", e, {o_out_oe_n, pin});
    endtask
    task automatic pstart();
        @(posedge i_clk) i_period_start <= 1'b1;
        @(posedge i_clk) i_period_start <= 1'b0;
        #1;
    endtask
    task automatic dband(input logic v, input int on, input int off);
        int n;
        @(posedge i_clk) i_pwm <= v;
        step(1);
        chk("turn off", 8'h00, {7'h00, pin[off]});
        for (n = 1; n < 20 && !pin[on]; n++) step(1);
        chk("turn on", db + 8'h01, n[7:0]);
    endtask
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard, far beyond the scripted run
    initial begin
        #40000;
        fail_count++;
        final_report();
    end

    initial begin
        rst_tab = '{RESET_CAPTURE_PWM_CONTROL, RESET_AUTO_SHUTDOWN_CONTROL,
            RESET_RESTART_AND_DEADBAND, {3'h0, RESET_STEER_CONTROL}, 8'h00,
            {4'h0, RESET_PORT_LATCH}, 8'h00, 8'h00};
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        wr(3'h6, 8'hFF);
        for (int a = 0; a < 8; a++) rchk(a[2:0], rst_tab[a]);
        pchk(8'h00);
        wr(ADDR_PORT_LATCH, 8'h0A);
        wr(ADDR_CAPTURE_PWM_CONTROL, 8'h0C);
        @(posedge i_clk) i_pwm <= 1'b1;
        step(2);
        pchk(8'h0A);
        pstart();
        step(1);
        pchk(8'h0B);
        rchk(ADDR_STATUS, 8'h04);
        pstart();
        rchk(ADDR_STATUS, 8'h05);
        chk("flag", 8'h01, {7'h00, o_period_timer_flag});
        wr(ADDR_STATUS, 8'h00);
        rchk(ADDR_STATUS, 8'h04);
        chk("flag", 8'h00, {7'h00, o_period_timer_flag});
        wr(ADDR_STEER_CONTROL, 8'h0F);
        wr(ADDR_CAPTURE_PWM_CONTROL, 8'h0D);
        step(1);
        pchk(8'h05);
        wr(ADDR_CAPTURE_PWM_CONTROL, 8'h0C);
        step(1);
        pchk(8'h0F);
        wr(ADDR_STEER_CONTROL, 8'h11);
        step(2);
        pchk(8'h0F);
        pstart();
        step(1);
        pchk(8'h0B);
        wr(ADDR_STEER_CONTROL, 8'h05);
        wr(ADDR_AUTO_SHUTDOWN_CONTROL, 8'h42);
        @(posedge i_clk) i_shutdown_pin_n <= 1'b0;
        #1 pchk(8'h0A);
        rchk(ADDR_AUTO_SHUTDOWN_CONTROL, 8'hC2);
        wr(ADDR_AUTO_SHUTDOWN_CONTROL, 8'h42);
        rchk(ADDR_AUTO_SHUTDOWN_CONTROL, 8'hC2);
        @(posedge i_clk) i_shutdown_pin_n <= 1'b1;
        wr(ADDR_AUTO_SHUTDOWN_CONTROL, 8'h42);
        rchk(ADDR_AUTO_SHUTDOWN_CONTROL, 8'h42);
        step(2);
        pchk(8'h0A);
        pstart();
        step(1);
        pchk(8'h0F);
        wr(ADDR_STEER_CONTROL, 8'h0F);
        wr(ADDR_AUTO_SHUTDOWN_CONTROL, 8'h1A);
        wr(ADDR_RESTART_AND_DEADBAND, 8'h80);
        @(posedge i_clk) i_cmp1 <= 1'b1;
        #1 pchk(8'hF0);
        step(3);
        pchk(8'hF0);
        @(posedge i_clk) i_cmp1 <= 1'b0;
        step(2);
        rchk(ADDR_AUTO_SHUTDOWN_CONTROL, 8'h1A);
        pchk(8'h00);
        pstart();
        step(1);
        pchk(8'h0F);
        wr(ADDR_AUTO_SHUTDOWN_CONTROL, 8'h81);
        pchk(8'h0A);
        pstart();
        step(1);
        pchk(8'h0F);
        wr(ADDR_AUTO_SHUTDOWN_CONTROL, 8'h00);
        wr(ADDR_CAPTURE_PWM_CONTROL, 8'h8C);
        wr(ADDR_RESTART_AND_DEADBAND, db);
        pstart();
        pstart();
        step(6);
        pchk(8'h09);
        dband(1'b0, 1, 0);
        dband(1'b1, 0, 1);
        wr(ADDR_CAPTURE_PWM_CONTROL, 8'hCC);
        step(1);
        pchk(8'h06);
        wr(ADDR_CAPTURE_PWM_CONTROL, 8'h0C);
        pstart();
        step(1);
        pchk(8'h0F);
        wr(ADDR_AUTO_SHUTDOWN_CONTROL, 8'h20);
        @(posedge i_clk) i_comparator_two_sync <= 1'b1;
        i_cmp2 <= 1'b1;
        step(3);
        pchk(8'h0F);
        @(posedge i_clk) i_sec_timer_edge <= 1'b1;
        @(posedge i_clk) i_sec_timer_edge <= 1'b0;
        #1 pchk(8'h00);
        final_report();
    end
endmodule // tb

bind bridge_pwm_output_stage bridge_pwm_checker chk_i (.i_clk, .i_reset_n,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_pwm, .i_period_start,
    .i_cmp1, .i_cmp2, .i_comparator_two_sync, .i_sec_timer_edge,
    .i_shutdown_pin_n, .o_period_timer_flag, .o_out, .o_out_oe_n);
